/* sms_regs.svh */
// offsets, field positions, defaults and timing counts of the supervisor
`ifndef SMS_REGS_SVH
`define SMS_REGS_SVH
`define SMS_CMD_WD_BIT     7
`define SMS_CMD_ADDR_HI    6
`define SMS_CMD_ADDR_LO    4
`define SMS_ADDR_OUT_CMD   3'h0
`define SMS_ADDR_CONFIG    3'h1
`define SMS_ADDR_OC_LEVEL  3'h2
`define SMS_ADDR_OC_TIME   3'h3
`define SMS_ADDR_IN_EN     3'h4
`define SMS_CFG_OVERVOLTAGE_DISABLE     0
`define SMS_CFG_UNDERVOLTAGE_DISABLE     1
`define SMS_OCL_DEF        3'h0
`define SMS_OCH_DEF        1'h0
`define SMS_OCT_DEF        2'h0
`define SMS_SPI_BITS       4'h8
`define SMS_MCLK_HZ        250000000
`define SMS_WD_BASE_MS     10
`define SMS_WD_BASE_CYCLES (`SMS_WD_BASE_MS * (`SMS_MCLK_HZ / 1000))
`endif

/* sms_pkg.sv */
// types of the switch mode and fault supervisor
package sms_pkg;
  typedef enum logic [3:0] {
    SMS_SLEEP    = 4'b0001,
    SMS_NORMAL   = 4'b0010,
    SMS_FAULT    = 4'b0100,
    SMS_FAILSAFE = 4'b1000
  } sms_mode_t;
  typedef enum logic [1:0] {
    SMS_FS_DISABLED = 2'h0,
    SMS_FS_BOTH_OFF = 2'h1,
    SMS_FS_CH0_ON   = 2'h2,
    SMS_FS_BOTH_ON  = 2'h3
  } sms_fs_code_t;
endpackage

/* sms_supervisor.sv */
// mode, watchdog, fail-safe and fault-flag supervisor of a dual power switch
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "sms_regs.svh"

module sms_supervisor
  import sms_pkg::*;
#(
  parameter logic [31:0] WD_BASE_CYCLES = 32'(`SMS_WD_BASE_CYCLES)
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       si,
  input  wire logic       wake,
  input  wire logic       rst_pin,
  input  wire logic [1:0] direct_inputs,
  input  wire logic       failsafe_select_input,
  input  wire logic       vdd_ok,
  input  wire logic [1:0] failsafe_resistor_code,
  input  wire logic [1:0] overtemp,
  input  wire logic [1:0] open_load,
  input  wire logic [1:0] overcurrent,
  input  wire logic       overvoltage,
  input  wire logic       undervoltage,
  input  wire logic       below_2v5,
  output logic            so_out,
  output logic            so_oe,
  output logic [1:0]      switch_outputs,
  output logic            fault_flag_n_out,
  output logic            fault_flag_n_oe,
  output logic            watchdog_timeout_flag,
  output sms_mode_t       mode,
  output logic [2:0]      oc_low_level_field,
  output logic            oc_high_level_field,
  output logic [1:0]      oc_low_time_field
);
  localparam int NP = 9;
  // chip select idles high; resetting its stages low would fake a select edge
  localparam logic [NP-1:0] SYNC_IDLE = 9'h004;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one is read only by stage two
  logic [NP-1:0] sync1;
  logic [NP-1:0] sync2;
  logic [NP-1:0] sync3;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
      sync3 <= SYNC_IDLE;
    end else begin
      sync1 <= {vdd_ok, failsafe_select_input, rst_pin, wake, si, sclk, cs_n,
                direct_inputs};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  logic [1:0] din_s;
  logic       cs_s, sclk_s, si_s, wake_s, rst_s, fsi_s, vdd_s;
  assign {vdd_s, fsi_s, rst_s, wake_s, si_s, sclk_s, cs_s, din_s} = sync2;
  logic sclk_rise, cs_fall, cs_rise, wake_rise, rst_rise;
  assign sclk_rise = sclk_s & ~sync3[3] & ~cs_s;
  assign cs_fall   = ~cs_s & sync3[2];
  assign cs_rise   = cs_s & ~sync3[2];
  assign wake_rise = wake_s & ~sync3[5];
  assign rst_rise  = rst_s & ~sync3[6];

  //////////////////////////////////////////////////////////////////////////
  // state
  sms_mode_t   next_mode;
  logic [7:0]  rx, next_rx, tx, next_tx;
  logic [3:0]  bits, next_bits;
  logic [1:0]  out_cmd, next_out_cmd, in_en, next_in_en;
  logic [3:0]  cfg, next_cfg;
  logic [2:0]  ocl, next_ocl;
  logic        och, next_och;
  logic [1:0]  oct, next_oct;
  logic        wd_last, next_wd_last, wd_armed, next_wd_armed;
  logic [31:0] wd_cnt, next_wd_cnt;
  logic [1:0]  oc_latch, next_oc_latch, uv_latch, next_uv_latch;
  logic        ot_st, next_ot_st, ov_st, next_ov_st, uv_st, next_uv_st;
  logic        oc_st, next_oc_st, ol_st, next_ol_st;
  logic [1:0]  next_sw;
  logic        next_flag_oe, next_so_oe;

  // decode of the fail-safe resistor code into channel states
  function automatic logic [1:0] fs_pattern(input sms_fs_code_t c);
    unique case (c)
      SMS_FS_DISABLED: fs_pattern = 2'h0;
      SMS_FS_BOTH_OFF: fs_pattern = 2'h0;
      SMS_FS_CH0_ON:   fs_pattern = 2'h1;
      SMS_FS_BOTH_ON:  fs_pattern = 2'h3;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // next-state logic
  logic        valid_xfer, overvoltage_disable, undervoltage_disable, ov_act, uv_act, kick, timeout;
  logic [1:0]  cmd, ot_seen;
  logic [31:0] wd_limit;
  always_comb begin
    next_rx       = rx;
    next_tx       = tx;
    next_bits     = bits;
    next_out_cmd  = out_cmd;
    next_in_en    = in_en;
    next_cfg      = cfg;
    next_ocl      = ocl;
    next_och      = och;
    next_oct      = oct;
    next_wd_last  = wd_last;
    next_wd_armed = wd_armed;
    next_wd_cnt   = wd_cnt;
    next_mode     = mode;
    // only an exact 8-bit frame counts as valid
    valid_xfer = cs_rise & (bits == `SMS_SPI_BITS);
    // serial features forced to zero while asleep
    overvoltage_disable = (mode != SMS_SLEEP) & cfg[`SMS_CFG_OVERVOLTAGE_DISABLE];
    undervoltage_disable = (mode != SMS_SLEEP) & cfg[`SMS_CFG_UNDERVOLTAGE_DISABLE];
    ov_act = overvoltage & ~overvoltage_disable;
    uv_act = undervoltage & (~undervoltage_disable | below_2v5);
    kick   = valid_xfer & (rx[`SMS_CMD_WD_BIT] != wd_last);
    wd_limit = WD_BASE_CYCLES << cfg[3:2];               // rate field
    timeout  = wd_armed & (wd_cnt >= wd_limit - 32'h1);

    // serial shifter: capture on rising clock, msb first
    if (cs_fall) begin
      next_bits = 4'h0;
      next_tx = {~fault_flag_n_oe ? 1'b0 : 1'b1, oc_st, ol_st, ot_st, uv_st,
                 mode == SMS_FAILSAFE, ov_st, fsi_s};
    end else if (sclk_rise) begin
      next_rx = {rx[6:0], si_s};
      next_tx = {tx[6:0], 1'b0};
      if (bits != 4'hF) begin
        next_bits = bits + 4'h1;
      end
    end
    if (valid_xfer) begin
      next_wd_last = rx[`SMS_CMD_WD_BIT];
      unique case (rx[`SMS_CMD_ADDR_HI:`SMS_CMD_ADDR_LO])
        `SMS_ADDR_OUT_CMD:  next_out_cmd = rx[1:0];
        `SMS_ADDR_CONFIG:   next_cfg = rx[3:0];
        `SMS_ADDR_OC_LEVEL: next_ocl = rx[2:0];
        `SMS_ADDR_OC_TIME:  {next_och, next_oct} = rx[2:0];
        `SMS_ADDR_IN_EN:    next_in_en = rx[1:0];
        default:            next_in_en = in_en;
      endcase
    end

    // watchdog: armed by rising wake or reset while select is high
    if (!fsi_s) begin
      next_wd_armed = 1'b0;
    end else if (wake_rise | rst_rise) begin
      next_wd_armed = 1'b1;
    end
    if (!next_wd_armed | kick | wake_rise | rst_rise) begin
      next_wd_cnt = 32'h0;
    end else if (!timeout) begin
      next_wd_cnt = wd_cnt + 32'h1;
    end

    // mode selection
    if (!wake_s & !rst_s) begin
      next_mode     = SMS_SLEEP;
      next_wd_armed = 1'b0;
    end else if (mode == SMS_FAILSAFE & fsi_s) begin
      next_mode = SMS_FAILSAFE;
    end else if (timeout & fsi_s) begin
      next_mode = SMS_FAILSAFE;
      next_ocl  = `SMS_OCL_DEF;
      next_och  = `SMS_OCH_DEF;
      next_oct  = `SMS_OCT_DEF;
    end else if (!fault_flag_n_oe & rst_s & ~ov_act & ~uv_act) begin
      next_mode = SMS_NORMAL;
    end else if (fault_flag_n_oe | ov_act | uv_act) begin
      next_mode = SMS_FAULT;
    end else begin
      next_mode = SMS_SLEEP;
    end

    // reset pin low or lost logic supply wipes configuration
    if (!rst_s | !vdd_s) begin
      next_out_cmd = 2'h0;
      next_in_en   = 2'h0;
      next_cfg     = 4'h0;
      next_ocl     = `SMS_OCL_DEF;
      next_och     = `SMS_OCH_DEF;
      next_oct     = `SMS_OCT_DEF;
    end

    // channel command: fail-safe pattern beats everything else; it follows the
    // mode being entered so outputs never lag the mode by a cycle
    if (next_mode == SMS_FAILSAFE) begin
      cmd = fs_pattern(sms_fs_code_t'(failsafe_resistor_code));
    end else if (next_mode == SMS_SLEEP) begin
      cmd = 2'h0;
    end else if (!vdd_s) begin
      cmd = din_s;
    end else begin
      cmd = out_cmd | (in_en & din_s);
    end

    // latched faults clear only when the command drops
    next_oc_latch = (oc_latch | (overcurrent & cmd)) & cmd;
    next_uv_latch = (uv_latch | ({2{uv_act}} & cmd)) & cmd;
    ot_seen = overtemp & cmd;
    next_sw = cmd & ~ot_seen & ~next_oc_latch & ~next_uv_latch
              & ~{2{ov_act | uv_act}};
    next_flag_oe = (|ot_seen) | (|open_load) | (|next_oc_latch) | ov_act
                   | uv_act | (|next_uv_latch);

    // status bits: a new event wins over the clearing read
    next_ot_st = (ot_st & ~valid_xfer) | (|ot_seen);
    next_ov_st = (ov_st & ~valid_xfer) | ov_act;
    next_uv_st = (uv_st & ~valid_xfer) | uv_act;
    next_oc_st = (oc_st & ~valid_xfer) | (|(overcurrent & cmd));
    next_ol_st = (ol_st & ~valid_xfer) | (|open_load);
    if (!rst_s) begin
      next_ot_st = 1'b0;
      next_ov_st = 1'b0;
      next_uv_st = 1'b0;
      next_oc_st = 1'b0;
      next_ol_st = 1'b0;
    end
    next_so_oe = ~cs_s;
  end

  //////////////////////////////////////////////////////////////////////////
  // registers; power-on reset lands in sleep
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode                  <= SMS_SLEEP;
      rx                    <= 8'h00;
      tx                    <= 8'h00;
      bits                  <= 4'h0;
      out_cmd               <= 2'h0;
      in_en                 <= 2'h0;
      cfg                   <= 4'h0;
      ocl                   <= `SMS_OCL_DEF;
      och                   <= `SMS_OCH_DEF;
      oct                   <= `SMS_OCT_DEF;
      wd_last               <= 1'b0;
      wd_armed              <= 1'b0;
      wd_cnt                <= 32'h0;
      oc_latch              <= 2'h0;
      uv_latch              <= 2'h0;
      ot_st                 <= 1'b0;
      ov_st                 <= 1'b0;
      uv_st                 <= 1'b0;
      oc_st                 <= 1'b0;
      ol_st                 <= 1'b0;
      switch_outputs        <= 2'h0;
      fault_flag_n_oe       <= 1'b0;
      fault_flag_n_out      <= 1'b0;
      so_oe                 <= 1'b0;
      so_out                <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
      oc_low_level_field    <= `SMS_OCL_DEF;
      oc_high_level_field   <= `SMS_OCH_DEF;
      oc_low_time_field     <= `SMS_OCT_DEF;
    end else begin
      mode                  <= next_mode;
      rx                    <= next_rx;
      tx                    <= next_tx;
      bits                  <= next_bits;
      out_cmd               <= next_out_cmd;
      in_en                 <= next_in_en;
      cfg                   <= next_cfg;
      ocl                   <= next_ocl;
      och                   <= next_och;
      oct                   <= next_oct;
      wd_last               <= next_wd_last;
      wd_armed              <= next_wd_armed;
      wd_cnt                <= next_wd_cnt;
      oc_latch              <= next_oc_latch;
      uv_latch              <= next_uv_latch;
      ot_st                 <= next_ot_st;
      ov_st                 <= next_ov_st;
      uv_st                 <= next_uv_st;
      oc_st                 <= next_oc_st;
      ol_st                 <= next_ol_st;
      switch_outputs        <= next_sw;
      fault_flag_n_oe       <= next_flag_oe;
      fault_flag_n_out      <= 1'b0;                     // open drain pulls low
      so_oe                 <= next_so_oe;
      so_out                <= next_tx[7];
      watchdog_timeout_flag <= (next_mode == SMS_FAILSAFE);
      oc_low_level_field    <= next_ocl;
      oc_high_level_field   <= next_och;
      oc_low_time_field     <= next_oct;
    end
  end
endmodule // sms_supervisor
`default_nettype wire

/* sms_supervisor_properties.sv */
// concurrent checks on the ports of the mode and fault supervisor
`timescale 1ns/1ps
`default_nettype none
module sms_supervisor_properties
  import sms_pkg::*;
(
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       cs_n,
  input wire logic       wake,
  input wire logic       rst_pin,
  input wire logic       failsafe_select_input,
  input wire logic [1:0] failsafe_resistor_code,
  input wire logic       so_oe,
  input wire logic [1:0] switch_outputs,
  input wire logic       watchdog_timeout_flag,
  input wire sms_mode_t  mode,
  input wire logic [2:0] oc_low_level_field,
  input wire logic       oc_high_level_field,
  input wire logic [1:0] oc_low_time_field
);
  logic [1:0] fs_expect;
  // channel states that each resistor code should give in fail-safe
  always_comb begin
    case (failsafe_resistor_code)
      2'h2:    fs_expect = 2'h1;
      2'h3:    fs_expect = 2'h3;
      default: fs_expect = 2'h0;
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  // pins pass two synchronisers and a register, so windows allow for that
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sleep_outputs_off_a: assert property (
    mode == SMS_SLEEP |-> switch_outputs == 2'h0) else $error("outputs on in sleep");
  sleep_entry_a: assert property (
    (!wake && !rst_pin)[*4] |-> mode == SMS_SLEEP) else $error("pins low but not asleep");
  normal_needs_rst_a: assert property (
    (!rst_pin)[*4] |-> mode != SMS_NORMAL) else $error("normal with reset pin low");
  timeout_flag_a: assert property (
    (mode == SMS_FAILSAFE)[*2] |-> watchdog_timeout_flag) else $error("timeout flag low");
  so_idle_a: assert property (
    cs_n[*4] |-> !so_oe) else $error("serial out driven while deselected");
  so_drive_a: assert property (
    (!cs_n)[*4] |-> so_oe) else $error("serial out idle while selected");
  fs_code_a: assert property (
    (mode == SMS_FAILSAFE && failsafe_resistor_code != SMS_FS_DISABLED
      && $stable(failsafe_resistor_code))[*4] |-> switch_outputs == fs_expect)
    else $error("fail-safe outputs disagree with code");
  fs_oc_default_a: assert property (
    (mode == SMS_FAILSAFE)[*2] |->
      {oc_high_level_field, oc_low_level_field, oc_low_time_field} == 6'h00)
    else $error("overcurrent fields kept in fail-safe");
  select_low_a: assert property (
    (!failsafe_select_input)[*5] |-> mode != SMS_FAILSAFE)
    else $error("fail-safe with select low");
  cover property (mode == SMS_FAILSAFE);
  cover property (mode == SMS_NORMAL && switch_outputs == 2'h3);
  cover property ($fell(watchdog_timeout_flag));
endmodule // sms_supervisor_properties
bind sms_supervisor sms_supervisor_properties u_props (.mclk, .reset_n, .cs_n, .wake, .rst_pin,
  .failsafe_select_input, .failsafe_resistor_code, .so_oe, .switch_outputs,
  .watchdog_timeout_flag, .mode, .oc_low_level_field, .oc_high_level_field, .oc_low_time_field);
`default_nettype wire

/* sms_host_model.sv */
// host controller model: serial master that frames commands and reads status
`timescale 1ns/1ps
`default_nettype none
module sms_host_model (
  input  wire logic mclk,
  input  wire logic so_out,
  input  wire logic so_oe,
  output logic      cs_n,
  output logic      sclk,
  output logic      si
);
  logic wd_toggle;
  // serial clock idles low and data sits at its pull-down level between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    wd_toggle = 1'b0;
  end
  // half of the 160 ns serial period at the 4 ns system clock
  task automatic half_bit();
    repeat (20) @(posedge mclk);
  endtask
  // one whole frame; bit 7 flips each time so every frame feeds the watchdog
  task automatic send(input logic [7:0] cmd, output logic [7:0] rx);
    wd_toggle = ~wd_toggle;
    @(posedge mclk);
    cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      si <= (i == 7) ? wd_toggle : cmd[i];
      half_bit();
      rx[i] = so_out & so_oe;
      sclk <= 1'b1;
      half_bit();
      sclk <= 1'b0;
    end
    half_bit();
    cs_n <= 1'b1;
    si <= 1'b0;
  endtask
endmodule // sms_host_model
`default_nettype wire

/* sms_supervisor_test.sv */
// self-checking bench of the mode and fault supervisor
`timescale 1ns/1ps
`default_nettype none
module sms_supervisor_test;
  import sms_pkg::*;
  typedef struct {
    logic [7:0] cmd;
    logic [1:0] dir;
    logic       ov;
    logic [1:0] outs;
    logic       flag;
    logic [7:0] status;
  } sms_row_t;
  logic       mclk, reset_n, cs_n, sclk, si, wake, rst_pin, failsafe_select_input;
  logic       overvoltage, undervoltage, vdd_ok, so_out, so_oe, fault_flag_n_oe;
  logic       watchdog_timeout_flag, oc_high_level_field;
  logic [1:0] direct_inputs, failsafe_resistor_code, switch_outputs, oc_low_time_field;
  logic [2:0] oc_low_level_field;
  logic [7:0] rx;
  sms_mode_t  mode;
  int         failures = 0;
  int         compares = 0;
  logic [1:0] fs_outs [4] = '{2'h0, 2'h0, 2'h1, 2'h3};
  // command, direct inputs, overvoltage, then outputs, flag and status expected
  sms_row_t   rows [10] = '{
    '{8'h01, 2'h0, 1'b0, 2'h1, 1'b0, 8'h01}, '{8'h03, 2'h0, 1'b0, 2'h3, 1'b0, 8'h01},
    '{8'h00, 2'h0, 1'b0, 2'h0, 1'b0, 8'h01}, '{8'h43, 2'h2, 1'b0, 2'h2, 1'b0, 8'h01},
    '{8'h03, 2'h0, 1'b1, 2'h0, 1'b1, 8'h83}, '{8'h03, 2'h0, 1'b0, 2'h3, 1'b0, 8'h03},
    '{8'h11, 2'h0, 1'b0, 2'h3, 1'b0, 8'h01}, '{8'h03, 2'h0, 1'b1, 2'h3, 1'b0, 8'h01},
    '{8'h10, 2'h0, 1'b0, 2'h3, 1'b0, 8'h01}, '{8'h27, 2'h0, 1'b0, 2'h3, 1'b0, 8'h01}};
  //////////////////////////////////////////////////////////////////////////////
  // short watchdog base so a timeout costs hundreds of cycles, not millions
  sms_supervisor #(.WD_BASE_CYCLES(32'h200)) u_dut (
    .mclk, .reset_n, .cs_n, .sclk, .si, .wake, .rst_pin, .direct_inputs,
    .failsafe_select_input, .vdd_ok, .failsafe_resistor_code, .overtemp(2'h0),
    .open_load(2'h0), .overcurrent(2'h0), .overvoltage, .undervoltage, .below_2v5(1'b0),
    .so_out, .so_oe, .switch_outputs, .fault_flag_n_out(), .fault_flag_n_oe,
    .watchdog_timeout_flag, .mode, .oc_low_level_field, .oc_high_level_field,
    .oc_low_time_field);
  sms_host_model u_host (.mclk, .so_out, .so_oe, .cs_n, .sclk, .si);
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // bounded wait; the caller compares the mode afterwards
  task automatic wait_mode(input sms_mode_t m, input int limit);
    for (int n = 0; n < limit && mode !== m; n++) @(posedge mclk);
    #1;
  endtask
  task automatic settle();
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task automatic summarize();
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // cuts a hang short well past the expected run of about 6400 cycles
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    summarize();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0; wake = 1'b0; rst_pin = 1'b0; direct_inputs = 2'h0;
    failsafe_select_input = 1'b0; failsafe_resistor_code = 2'h1;
    overvoltage = 1'b0; undervoltage = 1'b0; vdd_ok = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    check(8'(mode), 8'(SMS_SLEEP), "mode after reset");
    check(8'(switch_outputs), 8'h00, "outputs after reset");
    @(posedge mclk);
    reset_n <= 1'b1;
    failsafe_select_input <= 1'b1;
    wake <= 1'b1;
    rst_pin <= 1'b1;
    foreach (rows[i]) begin
      direct_inputs <= rows[i].dir;
      overvoltage <= rows[i].ov;
      settle();
      u_host.send(rows[i].cmd, rx);
      settle();
      check(rx, rows[i].status, "status word");
      check(8'(switch_outputs), 8'(rows[i].outs), "row outputs");
      check(8'(fault_flag_n_oe), 8'(rows[i].flag), "row flag");
    end
    check(8'(oc_low_level_field), 8'h07, "oc level written");
    wait_mode(SMS_FAILSAFE, 2000);
    check(8'(mode), 8'(SMS_FAILSAFE), "watchdog expiry");
    check(8'(watchdog_timeout_flag), 8'h01, "timeout flag");
    check(8'({oc_high_level_field, oc_low_level_field, oc_low_time_field}), 8'h00, "oc");
    for (int c = 1; c < 4; c++) begin
      failsafe_resistor_code <= 2'(c);
      direct_inputs <= 2'(c - 1);
      settle();
      check(8'(switch_outputs), 8'(fs_outs[c]), "fail-safe outputs");
    end
    failsafe_select_input <= 1'b0;
    direct_inputs <= 2'h0;
    settle();
    check(8'(mode), 8'(SMS_NORMAL), "exit by select low");
    repeat (1100) @(posedge mclk);
    check(8'(mode), 8'(SMS_NORMAL), "no watchdog with select low");
    u_host.send(8'h01, rx);
    undervoltage <= 1'b1;
    settle();
    check(8'(switch_outputs), 8'h00, "uv output");
    check(8'(fault_flag_n_oe), 8'h01, "uv flag");
    undervoltage <= 1'b0;
    settle();
    check(8'(fault_flag_n_oe), 8'h01, "uv flag held while on");
    u_host.send(8'h00, rx);
    settle();
    check(rx, 8'h88, "uv status");
    check(8'(fault_flag_n_oe), 8'h00, "uv flag released");
    // input enables are still set here, so only a real wipe turns channel 1 off
    vdd_ok <= 1'b0;
    direct_inputs <= 2'h2;
    settle();
    check(8'(switch_outputs), 8'h02, "direct inputs without logic supply");
    vdd_ok <= 1'b1;
    settle();
    check(8'(switch_outputs), 8'h00, "input enables wiped by supply loss");
    direct_inputs <= 2'h0;
    wake <= 1'b0;
    rst_pin <= 1'b0;
    settle();
    check(8'(mode), 8'(SMS_SLEEP), "sleep by pins");
    failsafe_select_input <= 1'b1;
    wake <= 1'b1;
    rst_pin <= 1'b1;
    wait_mode(SMS_FAILSAFE, 2000);
    check(8'(mode), 8'(SMS_FAILSAFE), "watchdog armed by pins");
    wake <= 1'b0;
    rst_pin <= 1'b0;
    settle();
    check(8'(mode), 8'(SMS_SLEEP), "exit by pins falling");
    check(8'(watchdog_timeout_flag), 8'h00, "timeout flag cleared");
    summarize();
  end
endmodule // sms_supervisor_test
`default_nettype wire
